// File: core/ebgp_pkg.sv
// Package: register map, field layout and reset values of the GPIO port
package ebgp_pkg;

    // Bus and port widths
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned PORT_W  = 8;

    // Register byte offsets (one aligned word each)
    localparam logic [7:0] OFS_PIN_LEVELS    = 8'h00;
    localparam logic [7:0] OFS_DIRECTION     = 8'h04;
    localparam logic [7:0] OFS_OUTPUT_LATCH  = 8'h08;
    localparam logic [7:0] OFS_ANALOG_CTRL   = 8'h0C;
    localparam logic [7:0] OFS_COMPARATOR    = 8'h10;

    // Reset values
    localparam logic [7:0] RST_DIRECTION     = 8'hFF;
    localparam logic [7:0] RST_OUTPUT_LATCH  = 8'h00;
    localparam logic [4:0] RST_ANALOG_SEL    = 5'h1F;
    localparam logic [2:0] RST_COMPARATOR    = 3'h0;

    // Analog select field: one bit per analog-capable pin
    localparam int unsigned AN_PIN0 = 0;
    localparam int unsigned AN_PIN1 = 1;
    localparam int unsigned AN_PIN2 = 2;
    localparam int unsigned AN_PIN3 = 3;
    localparam int unsigned AN_PIN5 = 4;

    // Comparator control field positions
    localparam int unsigned CMP_INPUTS_EN  = 0;
    localparam int unsigned CMP_ONE_OUT   = 1;
    localparam int unsigned CMP_TWO_OUT   = 2;

    // Pin indices of shared functions
    localparam int unsigned PIN_FOUR  = 4;
    localparam int unsigned PIN_FIVE  = 5;
    localparam int unsigned PIN_SIX   = 6;
    localparam int unsigned PIN_SEVEN = 7;

    // Bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pad drive pair for the whole port
    typedef struct packed {
        logic [PORT_W-1:0] level;
        logic [PORT_W-1:0] oe;
    } ebgp_pad_t;

    // Synchroniser state
    typedef struct packed {
        logic [PORT_W-1:0] stage1;
        logic [PORT_W-1:0] stage2;
    } ebgp_sync_t;

    // Whole register and bus state of the port
    typedef struct packed {
        logic [PORT_W-1:0] direction;
        logic [PORT_W-1:0] output_latch;
        logic [4:0]        analog_sel;
        logic [2:0]        comparator_control;
        logic              osc_mode;
        logic              osc_caught;
        logic              aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic              w_held;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
        ebgp_pad_t         pad;
    } ebgp_state_t;

endpackage

// File: core/ebgp_sync.sv
// Two-stage synchroniser for the port's pin inputs
`timescale 1ns/1ps
module ebgp_sync (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic [ebgp_pkg::PORT_W-1:0] pins_i,
    output logic      [ebgp_pkg::PORT_W-1:0] pins_o
);
    import ebgp_pkg::*;

    ebgp_sync_t state;
    ebgp_sync_t next_state;

    // First stage feeds only the second stage
    always_comb begin
        next_state.stage1 = pins_i;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pins_o = state.stage2;
endmodule

// File: core/ebgp_port.sv
// Eight-bit GPIO port with AXI4-Lite register access and shared pins
//
// Notes on behaviour
// R1: Eight independent pins, three registers each
// R2: Direction one turns driver off, input
// R3: Direction zero drives pin from latch
// R4: Pin register reads pins, writes latch
// R5: Latch register reads back latched value
// R6: Top two pins oscillator or I/O
// R7: Oscillator pins read zero in all registers
// R8: Pin four shares timer clock, comparator
// R9: Analog control selects analog on pins
// R10: Comparators claim pins zero to five
// R11: Reset: analog pins read zero, three digital
// R12: Direction still gates drivers on analog pins
// R13: Enabled peripheral takes over its pin
// R14: Single-edge writes, synchronised pin reads
`timescale 1ns/1ps
module ebgp_port (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // AXI4-Lite slave
    input  wire logic [ebgp_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                        s_axi_awvalid_i,
    output logic                             s_axi_awready_o,
    input  wire logic [ebgp_pkg::DATA_W-1:0] s_axi_wdata_i,
    input  wire logic [3:0]                  s_axi_wstrb_i,
    input  wire logic                        s_axi_wvalid_i,
    output logic                             s_axi_wready_o,
    output logic      [1:0]                  s_axi_bresp_o,
    output logic                             s_axi_bvalid_o,
    input  wire logic                        s_axi_bready_i,
    input  wire logic [ebgp_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                        s_axi_arvalid_i,
    output logic                             s_axi_arready_o,
    output logic      [ebgp_pkg::DATA_W-1:0] s_axi_rdata_o,
    output logic      [1:0]                  s_axi_rresp_o,
    output logic                             s_axi_rvalid_o,
    input  wire logic                        s_axi_rready_i,
    // Non-volatile oscillator selection: 1 = top pins are oscillator
    input  wire logic                        osc_config_i,
    // Peripheral sharing
    input  wire logic                        comparator_one_output_i,
    input  wire logic                        comparator_two_output_i,
    output logic                             timer_ext_clock_in_o,
    output logic      [4:0]                  analog_select_o,
    output logic      [2:0]                  comparator_control_o,
    // Package pins
    input  wire logic [ebgp_pkg::PORT_W-1:0] pad_in_i,
    output logic      [ebgp_pkg::PORT_W-1:0] pad_out_o,
    output logic      [ebgp_pkg::PORT_W-1:0] pad_oe_o
);
    import ebgp_pkg::*;

    ebgp_state_t        state;
    ebgp_state_t        next_state;
    logic [PORT_W-1:0]  pins_sync;
    logic [PORT_W-1:0]  analog_pins;
    logic [PORT_W-1:0]  cmp_in_pins;
    logic [PORT_W-1:0]  osc_pins;
    logic [PORT_W-1:0]  digital_read;
    logic [PORT_W-1:0]  dir_view;
    logic [PORT_W-1:0]  latch_view;
    logic               aw_take;
    logic               w_take;
    logic               ar_take;
    logic               have_aw;
    logic               have_w;
    logic [ADDR_W-1:0]  wr_addr;
    logic [DATA_W-1:0]  wr_data;
    logic [3:0]         wr_strb;

    // Pin levels pass two flops before software sees them [R14]
    ebgp_sync u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pins_i (pad_in_i),
        .pins_o (pins_sync)
    );

    // Pins claimed by analog, comparator inputs or the oscillator
    always_comb begin
        analog_pins            = '0;
        analog_pins[0]         = state.analog_sel[AN_PIN0];        // [R9]
        analog_pins[1]         = state.analog_sel[AN_PIN1];        // [R9]
        analog_pins[2]         = state.analog_sel[AN_PIN2];        // [R9]
        analog_pins[3]         = state.analog_sel[AN_PIN3];        // [R9]
        analog_pins[PIN_FIVE]  = state.analog_sel[AN_PIN5];        // [R9]
        cmp_in_pins            = '0;
        cmp_in_pins[3:0]       = {4{state.comparator_control[CMP_INPUTS_EN]}};
        osc_pins               = '0;
        osc_pins[PIN_SIX]      = state.osc_mode;                   // [R6]
        osc_pins[PIN_SEVEN]    = state.osc_mode;                   // [R6]
    end

    // Claimed pins read as zero on the digital path [R7] [R10] [R11] [R13]
    assign digital_read = pins_sync & ~(analog_pins | cmp_in_pins | osc_pins);
    // Oscillator pins hide their direction and latch bits [R7]
    assign dir_view     = state.direction & ~osc_pins;
    assign latch_view   = state.output_latch & ~osc_pins;              // [R5]

    // Channel handshakes; one write and one read in flight at most
    assign aw_take = s_axi_awvalid_i & ~state.aw_held & ~state.bvalid;
    assign w_take  = s_axi_wvalid_i & ~state.w_held & ~state.bvalid;
    assign ar_take = s_axi_arvalid_i & ~state.rvalid;
    assign have_aw = state.aw_held | aw_take;
    assign have_w  = state.w_held | w_take;
    assign wr_addr = state.aw_held ? state.awaddr : s_axi_awaddr_i;
    assign wr_data = state.w_held ? state.wdata : s_axi_wdata_i;
    assign wr_strb = state.w_held ? state.wstrb : s_axi_wstrb_i;

    // Next-state logic for registers, bus channels and pads
    always_comb begin
        next_state = state;

        // Oscillator selection is caught once after reset release [R6]
        if (!state.osc_caught) begin
            next_state.osc_caught = 1'b1;
            next_state.osc_mode   = osc_config_i;
        end

        // Hold an address or data beat that arrived alone
        if (aw_take) begin
            next_state.aw_held = 1'b1;
            next_state.awaddr  = s_axi_awaddr_i;
        end
        if (w_take) begin
            next_state.w_held = 1'b1;
            next_state.wdata  = s_axi_wdata_i;
            next_state.wstrb  = s_axi_wstrb_i;
        end

        // Write commits on the single edge that raises bvalid [R14]
        if (have_aw && have_w) begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = RESP_OKAY;
            case (wr_addr)
                OFS_PIN_LEVELS, OFS_OUTPUT_LATCH: begin
                    // Pin writes land in the latch, never on pins [R4] [R5]
                    if (wr_strb[0]) begin
                        next_state.output_latch = wr_data[PORT_W-1:0];
                    end
                end
                OFS_DIRECTION: begin
                    if (wr_strb[0]) begin
                        next_state.direction = wr_data[PORT_W-1:0]; // [R1]
                    end
                end
                OFS_ANALOG_CTRL: begin
                    if (wr_strb[0]) begin
                        next_state.analog_sel = wr_data[4:0];       // [R9]
                    end
                end
                OFS_COMPARATOR: begin
                    if (wr_strb[0]) begin
                        next_state.comparator_control = wr_data[2:0];
                    end
                end
                default: begin
                    next_state.bresp = RESP_SLVERR;
                end
            endcase
        end else if (state.bvalid && s_axi_bready_i) begin
            next_state.bvalid = 1'b0;
        end

        // Read answers one cycle after the address is taken
        if (ar_take) begin
            next_state.rvalid = 1'b1;
            next_state.rresp  = RESP_OKAY;
            next_state.rdata  = '0;
            case (s_axi_araddr_i)
                OFS_PIN_LEVELS: begin
                    next_state.rdata[PORT_W-1:0] = digital_read;    // [R4]
                end
                OFS_DIRECTION: begin
                    next_state.rdata[PORT_W-1:0] = dir_view;        // [R7]
                end
                OFS_OUTPUT_LATCH: begin
                    next_state.rdata[PORT_W-1:0] = latch_view;      // [R5]
                end
                OFS_ANALOG_CTRL: begin
                    next_state.rdata[4:0] = state.analog_sel;
                end
                OFS_COMPARATOR: begin
                    next_state.rdata[2:0] = state.comparator_control;
                end
                default: begin
                    next_state.rresp = RESP_SLVERR;
                end
            endcase
        end else if (state.rvalid && s_axi_rready_i) begin
            next_state.rvalid = 1'b0;
        end

        // Default pad drive: latch out, driver on while direction is zero.
        // Direction gates analog pins too; software keeps them inputs.
        next_state.pad.level = next_state.output_latch;             // [R3]
        next_state.pad.oe    = ~next_state.direction;          // [R2] [R12]

        // Comparator outputs take over pins four and five [R10] [R13]
        if (next_state.comparator_control[CMP_ONE_OUT]) begin
            next_state.pad.level[PIN_FOUR] = comparator_one_output_i; // [R8]
            next_state.pad.oe[PIN_FOUR]    = 1'b1;
        end
        if (next_state.comparator_control[CMP_TWO_OUT]) begin
            next_state.pad.level[PIN_FIVE] = comparator_two_output_i;
            next_state.pad.oe[PIN_FIVE]    = 1'b1;
        end

        // Oscillator owns the top pins; port never drives them [R6]
        if (next_state.osc_mode) begin
            next_state.pad.level[PIN_SEVEN:PIN_SIX] = 2'h0;
            next_state.pad.oe[PIN_SEVEN:PIN_SIX]    = 2'h0;
        end
    end

    // Single state register; reset leaves pins as inputs [R11]
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state                    <= '0;
            state.direction          <= RST_DIRECTION;          // [R2]
            state.output_latch       <= RST_OUTPUT_LATCH;
            state.analog_sel         <= RST_ANALOG_SEL;          // [R11]
            state.comparator_control <= RST_COMPARATOR;
            state.pad.oe             <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Ready signals are combinational from the held state
    assign s_axi_awready_o = ~state.aw_held & ~state.bvalid;
    assign s_axi_wready_o  = ~state.w_held & ~state.bvalid;
    assign s_axi_arready_o = ~state.rvalid;
    assign s_axi_bvalid_o  = state.bvalid;
    assign s_axi_bresp_o   = state.bresp;
    assign s_axi_rvalid_o  = state.rvalid;
    assign s_axi_rdata_o   = state.rdata;
    assign s_axi_rresp_o   = state.rresp;

    // Timer clock sees pin four's synchronised level [R8]
    assign timer_ext_clock_in_o = pins_sync[PIN_FOUR];
    assign analog_select_o      = state.analog_sel;
    assign comparator_control_o = state.comparator_control;

    // Pads come straight from flops
    assign pad_out_o = state.pad.level;
    assign pad_oe_o  = state.pad.oe;
endmodule

// File: testbench/ebgp_port_sva.sv
// Checker: port-level properties of the GPIO port
`timescale 1ns/1ps
module ebgp_port_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        osc_config_i,
    input wire logic        comparator_one_output_i,
    input wire logic        timer_ext_clock_in_o,
    input wire logic [4:0]  analog_select_o,
    input wire logic [2:0]  comparator_control_o,
    input wire logic [7:0]  pad_in_i,
    input wire logic [7:0]  pad_out_o,
    input wire logic [7:0]  pad_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] up;
    // Edges since reset; the synchroniser holds reset data until then
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    end
    chk_read_lat: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o) else $error("read answer late");
    chk_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)
        && $stable(s_axi_rresp_o)) else $error("read data moved");
    chk_ar_block: assert property (s_axi_rvalid_o
        |-> !s_axi_arready_o) else $error("read taken while busy");
    chk_resp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    chk_oe_on_write: assert property ($changed(pad_oe_o)
        |-> $rose(s_axi_bvalid_o)) else $error("drivers moved unasked");
    chk_osc_quiet: assert property (osc_config_i
        |-> pad_oe_o[7:6] == 2'h0 && pad_out_o[7:6] == 2'h0)
        else $error("oscillator pins driven");
    chk_reset_vals: assert property ($fell(rst_i)
        |-> analog_select_o == 5'h1F && comparator_control_o == 3'h0
        && pad_oe_o == 8'h00) else $error("reset state wrong");
    chk_cmp_pin: assert property (comparator_control_o[1]
        && $past(comparator_control_o[1]) |-> pad_oe_o[4]
        && pad_out_o[4] == $past(comparator_one_output_i))
        else $error("comparator not on pin four");
    chk_timer_sync: assert property (up == 2'h3
        |-> timer_ext_clock_in_o == $past(pad_in_i[4], 2))
        else $error("timer clock path wrong");
    cover property (s_axi_bvalid_o && s_axi_bready_i);
    cover property (s_axi_rvalid_o && s_axi_rready_i);
    cover property (comparator_control_o[1] && osc_config_i == 1'b0);
    cover property (comparator_control_o[2] && pad_oe_o[5]);
endmodule
bind ebgp_port ebgp_port_sva u_sva (.*);

// File: testbench/ebgp_board.sv
// Board-side model of the eight port pins
`timescale 1ns/1ps
module ebgp_board (
    input  wire logic [7:0] pad_out_i,
    input  wire logic [7:0] pad_oe_i,
    input  wire logic [7:0] drive_i,
    input  wire logic [7:0] drive_en_i,
    output logic      [7:0] pad_in_o
);
    // Port driver wins; else board source; else the pull-up
    assign pad_in_o = (pad_oe_i & pad_out_i)
        | (~pad_oe_i & drive_en_i & drive_i) | (~pad_oe_i & ~drive_en_i);
endmodule

// File: testbench/eight_bit_gpio_port_tb_top.sv
// Testbench: register and pin scenarios for the GPIO port
`timescale 1ns/1ps
module eight_bit_gpio_port_tb_top;
    import ebgp_pkg::*;
    logic        clk_i, rst_i, osc, cmp1, cmp2, tmr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic [7:0]  awaddr, araddr, pout, poe, pin, drv, den;
    logic [3:0]  strb;
    logic [31:0] wdata, rdata;
    logic [4:0]  an_sel;
    logic [2:0]  cmp_ctl;
    int          mismatches, checks_done;
    ebgp_port DUT (.clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .osc_config_i(osc),
        .comparator_one_output_i(cmp1), .comparator_two_output_i(cmp2),
        .timer_ext_clock_in_o(tmr), .analog_select_o(an_sel),
        .comparator_control_o(cmp_ctl), .pad_in_i(pin),
        .pad_out_o(pout), .pad_oe_o(poe));
    ebgp_board board (.pad_out_i(pout), .pad_oe_i(poe), .drive_i(drv),
        .drive_en_i(den), .pad_in_o(pin));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic conclude;
        if (mismatches == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    // A stalled handshake would hang the run, so it ends it
    task automatic stall(input int n);
        if (n >= 50) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            stall(n);
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, a > 8'h10 ? RESP_SLVERR : RESP_OKAY},
            {30'h0, bresp});
    endtask
    // Two idle edges first so pin changes clear the synchroniser
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        int n;
        repeat (2) @(posedge clk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
            stall(n);
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(nm, e, rdata);
        chk("rresp", {30'h0, a > 8'h10 ? RESP_SLVERR : RESP_OKAY},
            {30'h0, rresp});
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, osc, cmp1, cmp2} = 8'h00;
        {awaddr, araddr, wdata} = 48'h0;
        rst_i = 1'b1;
        drv = 8'h96;
        den = 8'hFF;
        strb = 4'hF;
        mismatches = 0;
        checks_done = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("dir", OFS_DIRECTION, 32'hFF);
        rd("latch", OFS_OUTPUT_LATCH, 32'h00);
        rd("analog", OFS_ANALOG_CTRL, 32'h1F);
        rd("pins", OFS_PIN_LEVELS, 32'h90);
        rd("hole", 8'h14, 32'h0);
        wr(8'h14, 32'hFF);
        wr(OFS_ANALOG_CTRL, 32'h0);
        wr(OFS_OUTPUT_LATCH, 32'hA5);
        wr(OFS_DIRECTION, 32'h0F);
        chk("pad_oe", 32'hF0, {24'h0, poe});
        chk("pad_out", 32'hA0, {24'h0, pout & poe});
        rd("pins", OFS_PIN_LEVELS, 32'hA6);
        drv <= 8'h69;
        rd("pins", OFS_PIN_LEVELS, 32'hA9);
        rd("latch", OFS_OUTPUT_LATCH, 32'hA5);
        wr(OFS_PIN_LEVELS, 32'h3C);
        rd("latch", OFS_OUTPUT_LATCH, 32'h3C);
        // Lane zero off: the write is answered but leaves the latch
        strb <= 4'hE;
        wr(OFS_OUTPUT_LATCH, 32'h00);
        strb <= 4'hF;
        rd("latch", OFS_OUTPUT_LATCH, 32'h3C);
        wr(OFS_ANALOG_CTRL, 32'h1F);
        wr(OFS_DIRECTION, 32'h00);
        chk("pad_oe", 32'hFF, {24'h0, poe});
        rd("pins", OFS_PIN_LEVELS, 32'h10);
        wr(OFS_DIRECTION, 32'hFF);
        wr(OFS_ANALOG_CTRL, 32'h0);
        cmp1 <= 1'b1;
        wr(OFS_COMPARATOR, 32'h7);
        chk("pin4_out", 32'h10, {24'h0, pout & poe});
        chk("cmp_oe", 32'h30, {24'h0, poe});
        rd("pins", OFS_PIN_LEVELS, 32'h50);
        chk("timer", 32'h1, {31'h0, tmr});
        cmp1 <= 1'b0;
        cmp2 <= 1'b1;
        rd("cmp", OFS_COMPARATOR, 32'h7);
        chk("timer", 32'h0, {31'h0, tmr});
        chk("cmp_out", 32'h20, {24'h0, pout & poe});
        wr(OFS_COMPARATOR, 32'h0);
        rd("pins", OFS_PIN_LEVELS, 32'h69);
        // Second reset: top pins to the oscillator, board on pull-ups
        rst_i <= 1'b1;
        osc <= 1'b1;
        den <= 8'h00;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("dir", OFS_DIRECTION, 32'h3F);
        wr(OFS_OUTPUT_LATCH, 32'hFF);
        rd("latch", OFS_OUTPUT_LATCH, 32'h3F);
        rd("pins", OFS_PIN_LEVELS, 32'h10);
        wr(OFS_DIRECTION, 32'h00);
        chk("pad_oe", 32'h3F, {24'h0, poe});
        conclude();
    end
endmodule
